// ===== verilog/aopc_defines.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: ref_clk at 100 MHz
// Notes:   included by its bare name
`ifndef AOPC_DEFINES_SVH
`define AOPC_DEFINES_SVH
// register byte addresses
`define AOPC_REG_CTRL      8'h00
`define AOPC_REG_RESULT    8'h04
`define AOPC_REG_STATUS    8'h08
// control fields
`define AOPC_CTRL_EN_BIT   0
`define AOPC_CTRL_RESET    1'b1
// status field positions
`define AOPC_ST_SER_BIT    0
`define AOPC_ST_EXT_BIT    1
`define AOPC_ST_RDC_BIT    2
`define AOPC_ST_BUSY_BIT   3
`define AOPC_ST_CNT_LSB    8
// axi responses
`define AOPC_RESP_OKAY     2'b00
`define AOPC_RESP_SLVERR   2'b10
// clock period and least serial clock periods per divider code
`define AOPC_CLK_NS        10
`define AOPC_TSCLK0_NS     25
`define AOPC_TSCLK1_NS     50
`define AOPC_TSCLK2_NS     100
`define AOPC_TSCLK3_NS     200
// least times round up to whole cycles
`define AOPC_CYC(ns)       (((ns) + `AOPC_CLK_NS - 1) / `AOPC_CLK_NS)
`define AOPC_TSCLK0_CYC    `AOPC_CYC(`AOPC_TSCLK0_NS)
`define AOPC_TSCLK1_CYC    `AOPC_CYC(`AOPC_TSCLK1_NS)
`define AOPC_TSCLK2_CYC    `AOPC_CYC(`AOPC_TSCLK2_NS)
`define AOPC_TSCLK3_CYC    `AOPC_CYC(`AOPC_TSCLK3_NS)
// daisy-chain delay in serial clock periods
`define AOPC_CHAIN_DELAY   16
`endif

// ===== verilog/aopc_pkg.sv
// Purpose: shared types of the output port block
// Assumes: nothing
// Notes:   constants live in aopc_defines.svh
package aopc_pkg;
  // serial engine state
  typedef enum logic {
    st_idle,
    st_shift
  } aopc_state_t;
endpackage : aopc_pkg

// ===== verilog/aopc_output_port.sv
// Purpose: output port configuration and pin sharing of a 16-bit converter
// Assumes: conversion core on ref_clk; mode pins static during a read
// Notes:   AXI4-Lite slave for enable, result and status
// Overview of operation
// - byte select high swaps result bytes
// - code format low inverts result msb
// - serial select high turns port serial
// - serial mode floats data bits 0, 1
// - bits 2..7 become config inputs serially
// - divider slows clock only master after-convert
// - divider ignored in other serial modes
// - internal clock driven out on clock pin
// - external clock times data when selected
// - frame polarity input flips frame sync
// - clock invert flips serial clock polarity
// - read mode picks during or after convert, master only
// - chain input reappears sixteen clocks later
// - divider codes give 30/50/100/200 ns
// - serial data driven on data bit 8
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "aopc_defines.svh"
module aopc_output_port #(
  parameter int RES_W  = 16,  // result width
  parameter int ADDR_W = 8    // axi address width
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // conversion core, same clock
  input  wire logic [RES_W-1:0]  conv_result,
  input  wire logic              conv_done,
  input  wire logic              conv_busy,
  // static select pins
  input  wire logic              byte_order_select,
  input  wire logic              output_code_format,
  input  wire logic              serial_parallel_select,
  // shared data bus
  input  wire logic [RES_W-1:0]  data_in,
  output logic [RES_W-1:0]       data_out,
  output logic [RES_W-1:0]       data_oe,
  // serial clock and frame pins
  input  wire logic              serial_clock_in,
  output logic                   serial_clock_out,
  output logic                   serial_clock_oe,
  output logic                   frame_sync_out,
  output logic                   frame_sync_oe,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  localparam int CW = $clog2(RES_W + 1);  // bit counter width
  localparam int SW = 10;                 // synchronised pin count
  localparam int PW = 5;                  // clock period counter width

  // the shared-line mapping needs bits 0..8 and an even byte split
  if (RES_W < 16 || RES_W % 2 != 0) begin : g_check
    $error("aopc_output_port: RES_W must be even and at least 16");
  end

  // pin synchroniser, two stages
  logic [SW-1:0] sync1_q, sync2_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {serial_clock_in, data_in[7:2], serial_parallel_select,
                  output_code_format, byte_order_select};
      sync2_q <= sync1_q;
    end
  end

  // synchronised view of the pins
  logic       bos_s;       // byte order
  logic       ocf_s;       // code format
  logic       ser_s;       // serial mode
  logic [1:0] div_s;       // clock divider code
  logic       ext_s;       // external clock source
  logic       fpi_s;       // frame polarity
  logic       sci_s;       // clock invert
  logic       rdc_s;       // read mode or chain data
  logic       sclk_s;      // external serial clock level
  assign bos_s  = sync2_q[0];
  assign ocf_s  = sync2_q[1];
  assign ser_s  = sync2_q[2];
  // config lines are only meaningful as inputs in serial mode
  assign div_s  = sync2_q[4:3];
  assign ext_s  = sync2_q[5];
  assign fpi_s  = sync2_q[6];
  assign sci_s  = sync2_q[7];
  assign rdc_s  = sync2_q[8];
  assign sclk_s = sync2_q[9];

  // straight binary or twos complement, then optional byte swap
  function automatic logic [RES_W-1:0] fmt_word(
    input logic [RES_W-1:0] raw,
    input logic             ocf,
    input logic             bos
  );
    logic [RES_W-1:0] f;
    f = raw;
    if (!ocf) begin
      f[RES_W-1] = ~raw[RES_W-1];
    end
    if (bos) begin
      f = {f[RES_W/2-1:0], f[RES_W-1:RES_W/2]};
    end
    return f;
  endfunction : fmt_word

  // state registers
  logic                 en_q, en_d;          // port enable
  logic [RES_W-1:0]     res_q, res_d;        // last raw result
  logic [RES_W-1:0]     dout_q, dout_d;      // data bus output
  logic [RES_W-1:0]     shreg_q, shreg_d;    // serial shift register
  logic [CW-1:0]        bits_q, bits_d;      // bits shifted
  logic [PW-1:0]        cnt_q, cnt_d;        // clock phase counter
  logic                 sclk_q, sclk_d;      // internal clock level
  logic                 frame_q, frame_d;    // frame active
  logic                 busy_q, busy_d;      // conversion busy, delayed
  logic                 eclk_q, eclk_d;      // external clock, delayed
  aopc_pkg::aopc_state_t state_q, state_d;   // serial engine
  // axi registers
  logic                 awf_q, awf_d;        // write address held
  logic                 wf_q, wf_d;          // write data held
  logic [ADDR_W-1:0]    awa_q, awa_d;
  logic [31:0]          wdat_q, wdat_d;
  logic [3:0]           wstb_q, wstb_d;
  logic                 bv_q, bv_d;
  logic [1:0]           br_q, br_d;
  logic                 rv_q, rv_d;
  logic [1:0]           rr_q, rr_d;
  logic [31:0]          rdat_q, rdat_d;

  // combinational helpers
  logic [RES_W-1:0] word_last;   // formatted stored result
  logic [RES_W-1:0] word_new;    // formatted incoming result
  logic [PW-1:0]    period;      // internal clock period in cycles
  logic             master;      // serial with internal clock
  logic             start;       // master read begins
  logic             act_edge;    // external clock active edge
  logic             eclk_pol;    // external clock after inversion
  logic [31:0]      status;

  assign word_last = fmt_word(res_q, ocf_s, bos_s);
  assign word_new  = fmt_word(conv_result, ocf_s, bos_s);
  assign master    = ser_s && !ext_s && en_q;
  assign eclk_pol  = sclk_s ^ sci_s;
  // data leaves on the falling edge of the polarity-adjusted clock
  assign act_edge  = eclk_q && !eclk_pol;

  // divider only in master read-after-convert, else fastest clock
  always_comb begin
    period = PW'(`AOPC_TSCLK0_CYC);
    if (!rdc_s) begin
      case (div_s)
        2'b00:   period = PW'(`AOPC_TSCLK0_CYC);
        2'b01:   period = PW'(`AOPC_TSCLK1_CYC);
        2'b10:   period = PW'(`AOPC_TSCLK2_CYC);
        default: period = PW'(`AOPC_TSCLK3_CYC);
      endcase
    end
  end

  // read during convert starts on busy rise, else on completion
  assign start = rdc_s ? (conv_busy && !busy_q) : conv_done;

  // status word
  always_comb begin
    status = '0;
    status[`AOPC_ST_SER_BIT]  = ser_s;
    status[`AOPC_ST_EXT_BIT]  = ext_s;
    status[`AOPC_ST_RDC_BIT]  = rdc_s;
    status[`AOPC_ST_BUSY_BIT] = (state_q == aopc_pkg::st_shift);
    status[`AOPC_ST_CNT_LSB +: CW] = bits_q;
  end

  // next-state logic for the port, the serial engine and the bus
  always_comb begin
    en_d    = en_q;
    res_d   = res_q;
    shreg_d = shreg_q;
    bits_d  = bits_q;
    cnt_d   = cnt_q;
    sclk_d  = sclk_q;
    frame_d = frame_q;
    state_d = state_q;
    busy_d  = conv_busy;
    eclk_d  = eclk_pol;
    awf_d   = awf_q;
    wf_d    = wf_q;
    awa_d   = awa_q;
    wdat_d  = wdat_q;
    wstb_d  = wstb_q;
    bv_d    = bv_q;
    br_d    = br_q;
    rv_d    = rv_q;
    rr_d    = rr_q;
    rdat_d  = rdat_q;
    // newest result is kept for parallel reads and streaming
    if (conv_done) begin
      res_d = conv_result;
    end
    // serial engine
    if (!ser_s || !en_q) begin
      // parallel mode or disabled: engine rests
      state_d = aopc_pkg::st_idle;
      sclk_d  = 1'b0;
      frame_d = 1'b0;
      cnt_d   = '0;
    end else if (master) begin
      case (state_q)
        aopc_pkg::st_idle: begin
          sclk_d  = 1'b0;
          frame_d = 1'b0;
          if (start) begin
            // after-convert uses the fresh word, streaming the last one
            shreg_d = rdc_s ? word_last : word_new;
            bits_d  = '0;
            cnt_d   = '0;
            frame_d = 1'b1;
            state_d = aopc_pkg::st_shift;
          end
        end
        aopc_pkg::st_shift: begin
          // low for the first half period, high for the rest
          if (cnt_q == period - PW'(1)) begin
            cnt_d  = '0;
            sclk_d = 1'b0;
            if (bits_q == CW'(RES_W - 1)) begin
              frame_d = 1'b0;
              bits_d  = CW'(RES_W);
              state_d = aopc_pkg::st_idle;
            end else begin
              shreg_d = {shreg_q[RES_W-2:0], 1'b0};
              bits_d  = bits_q + CW'(1);
            end
          end else begin
            cnt_d  = cnt_q + PW'(1);
            sclk_d = (cnt_q + PW'(1)) >= (period >> 1);
          end
        end
        default: state_d = aopc_pkg::st_idle;
      endcase
    end else begin
      // external clock: load on completion, shift on each active edge
      sclk_d = 1'b0;
      if (conv_done) begin
        shreg_d = word_new;
        bits_d  = '0;
        frame_d = 1'b1;
        state_d = aopc_pkg::st_shift;
      end else if (state_q == aopc_pkg::st_shift && act_edge) begin
        // chain data enters at the bottom and surfaces after 16 edges
        shreg_d = {shreg_q[RES_W-2:0], rdc_s};
        if (bits_q < CW'(RES_W)) begin
          bits_d = bits_q + CW'(1);
        end
        if (bits_q == CW'(RES_W - 1)) begin
          frame_d = 1'b0;
        end
      end
    end
    // axi write: address and data taken in either order
    if (s_axi_awvalid && !awf_q) begin
      awf_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wf_q) begin
      wf_d   = 1'b1;
      wdat_d = s_axi_wdata;
      wstb_d = s_axi_wstrb;
    end
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
    if (awf_q && wf_q && !bv_q) begin
      awf_d = 1'b0;
      wf_d  = 1'b0;
      bv_d  = 1'b1;
      br_d  = `AOPC_RESP_OKAY;
      case (awa_q)
        `AOPC_REG_CTRL: begin
          if (wstb_q[0]) begin
            en_d = wdat_q[`AOPC_CTRL_EN_BIT];
          end
        end
        // result and status are read-only; writes are dropped
        `AOPC_REG_RESULT, `AOPC_REG_STATUS: br_d = `AOPC_RESP_OKAY;
        default: br_d = `AOPC_RESP_SLVERR;
      endcase
    end
    // axi read
    if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
    if (s_axi_arvalid && !rv_q) begin
      rv_d   = 1'b1;
      rr_d   = `AOPC_RESP_OKAY;
      rdat_d = '0;
      case (s_axi_araddr)
        `AOPC_REG_CTRL:   rdat_d[`AOPC_CTRL_EN_BIT] = en_q;
        `AOPC_REG_RESULT: rdat_d[RES_W-1:0] = word_last;
        `AOPC_REG_STATUS: rdat_d = status;
        default:          rr_d = `AOPC_RESP_SLVERR;
      endcase
    end
    // data bus: parallel word, or serial bit on line 8
    if (ser_s) begin
      dout_d    = '0;
      dout_d[8] = shreg_d[RES_W-1];
    end else begin
      dout_d = word_last;
    end
  end

  // state registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      en_q    <= `AOPC_CTRL_RESET;
      res_q   <= '0;
      dout_q  <= '0;
      shreg_q <= '0;
      bits_q  <= '0;
      cnt_q   <= '0;
      sclk_q  <= 1'b0;
      frame_q <= 1'b0;
      busy_q  <= 1'b0;
      eclk_q  <= 1'b0;
      state_q <= aopc_pkg::st_idle;
      awf_q   <= 1'b0;
      wf_q    <= 1'b0;
      awa_q   <= '0;
      wdat_q  <= '0;
      wstb_q  <= '0;
      bv_q    <= 1'b0;
      br_q    <= '0;
      rv_q    <= 1'b0;
      rr_q    <= '0;
      rdat_q  <= '0;
    end else begin
      en_q    <= en_d;
      res_q   <= res_d;
      dout_q  <= dout_d;
      shreg_q <= shreg_d;
      bits_q  <= bits_d;
      cnt_q   <= cnt_d;
      sclk_q  <= sclk_d;
      frame_q <= frame_d;
      busy_q  <= busy_d;
      eclk_q  <= eclk_d;
      state_q <= state_d;
      awf_q   <= awf_d;
      wf_q    <= wf_d;
      awa_q   <= awa_d;
      wdat_q  <= wdat_d;
      wstb_q  <= wstb_d;
      bv_q    <= bv_d;
      br_q    <= br_d;
      rv_q    <= rv_d;
      rr_q    <= rr_d;
      rdat_q  <= rdat_d;
    end
  end

  // pin enables: serial floats bits 0..7 and 9..15
  always_comb begin
    data_oe = '0;
    if (en_q) begin
      if (ser_s) begin
        data_oe[8] = 1'b1;
      end else begin
        data_oe = '1;
      end
    end
  end

  assign data_out         = dout_q;
  assign serial_clock_out = sclk_q ^ sci_s;
  assign serial_clock_oe  = master;
  assign frame_sync_out   = frame_q ^ fpi_s;
  assign frame_sync_oe    = ser_s && en_q;
  // handshakes
  assign s_axi_awready = !awf_q;
  assign s_axi_wready  = !wf_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rresp   = rr_q;
  assign s_axi_rdata   = rdat_q;

endmodule : aopc_output_port

// ===== sim/aopc_port_asserts.sv
// Purpose: port checker for the converter output port
// Assumes: one clock domain, reset_n active low
// Notes:   bound into aopc_output_port below the module
`timescale 1ns/1ps
module aopc_port_asserts #(
  parameter int RES_W = 16  // result width
) (
  input wire logic             ref_clk,
  input wire logic             reset_n,
  input wire logic [RES_W-1:0] data_out,
  input wire logic [RES_W-1:0] data_oe,
  input wire logic             serial_clock_out,
  input wire logic             serial_clock_oe,
  input wire logic             frame_sync_oe,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  input wire logic             s_axi_arready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // two clock flips in a row; a third would beat the least period of three cycles
  sequence two_flips_s;
    serial_clock_oe && $changed(serial_clock_out) ##1 $changed(serial_clock_out);
  endsequence
  // serial mode held two cycles, so the registered data has caught up with the mode
  sequence ser_held_s;
    data_oe == 16'h0100 ##1 data_oe == 16'h0100;
  endsequence
  oe_shape_a: assert property (data_oe inside {16'h0000, 16'hffff, 16'h0100})
    else $error("data enable pattern illegal");
  par_quiet_a: assert property (&data_oe |-> !serial_clock_oe && !frame_sync_oe)
    else $error("serial pins driven in parallel mode");
  clk_oe_a: assert property (serial_clock_oe |-> data_oe == 16'h0100)
    else $error("clock driven outside serial mode");
  frame_oe_a: assert property (frame_sync_oe == (data_oe == 16'h0100))
    else $error("frame enable disagrees with mode");
  ser_data_a: assert property (ser_held_s |-> (data_out & 16'hfeff) == 16'h0000)
    else $error("serial mode drives more than data bit 8");
  clk_min_a: assert property (two_flips_s |=> $stable(serial_clock_out))
    else $error("serial clock faster than least period");
  bresp_done_a: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
    else $error("write response dropped without bready");
  rdata_done_a: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
    else $error("read data dropped without rready");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
endmodule : aopc_port_asserts

bind aopc_output_port aopc_port_asserts #(.RES_W(RES_W)) i_aopc_port_asserts (
  .ref_clk(ref_clk), .reset_n(reset_n), .data_out(data_out), .data_oe(data_oe),
  .serial_clock_out(serial_clock_out), .serial_clock_oe(serial_clock_oe),
  .frame_sync_oe(frame_sync_oe), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_arready(s_axi_arready)
);

// ===== sim/aopc_host_model.sv
// Purpose: host side of the converter output port
// Assumes: ref_clk 100 MHz, link clock period 80 ns
// Notes:   resolves the shared lines and captures serial words
`timescale 1ns/1ps
module aopc_host_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] data_out,
  input  wire logic [15:0] data_oe,
  input  wire logic        serial_clock_out,
  input  wire logic        serial_clock_oe,
  output logic [15:0]      data_in,
  output logic             serial_clock_in
);
  logic        ser   = 1'b0;   // host drives config lines in serial mode
  logic [7:2]  cfg   = 6'h00;  // config levels, only changed between reads
  logic [16:0] bits  = 17'h0;  // captured serial bits, newest in bit 0
  int          nbits = 0;      // bits captured so far
  int          per   = 0;      // cycles between the last two captures
  int          cyc   = 0;      // cycles since the last capture
  logic        prev  = 1'b0;   // previous uninverted clock level
  initial serial_clock_in = 1'b0;  // stands still outside frames
  // device enable wins; undriven config lines in serial mode show cfg, any other undriven line the inverse of the last value
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (data_oe[i])
        data_in[i] = data_out[i];
      else if (ser && i >= 2 && i <= 7)
        data_in[i] = cfg[i];
      else
        data_in[i] = ~data_out[i];
    end
  end
  // master capture on the rising edge of the uninverted clock; data moves on falling
  always @(posedge ref_clk) begin
    cyc  <= cyc + 1;
    prev <= serial_clock_out ^ cfg[6];
    if (serial_clock_oe && !prev && (serial_clock_out ^ cfg[6])) begin
      bits  <= {bits[15:0], data_out[8]};
      nbits <= nbits + 1;
      per   <= cyc + 1;
      cyc   <= 0;
    end
  end
  // slave read: sample late in the low phase, long after the device moved its data
  task automatic slave_read(input int n);
    #3;
    repeat (n) begin
      #36;
      bits = {bits[15:0], data_out[8]};
      #4 serial_clock_in = 1'b1;
      #40 serial_clock_in = 1'b0;
    end
  endtask : slave_read
endmodule : aopc_host_model

// ===== sim/aopc_output_port_test.sv
// Purpose: self-checking bench for the converter output port
// Assumes: 100 MHz ref_clk, link clock made by the host model
// Notes:   register, parallel, master serial and slave serial tests
`timescale 1ns/1ps
`include "aopc_defines.svh"
module aopc_output_port_test;
  logic        ref_clk = 1'b0, reset_n = 1'b0;
  logic [15:0] conv_result = 16'h0000, data_in, data_out, data_oe;
  logic        conv_done = 1'b0, conv_busy = 1'b0, serial_parallel_select = 1'b0;
  logic        byte_order_select = 1'b0, output_code_format = 1'b1;
  logic        serial_clock_in, serial_clock_out, serial_clock_oe, frame_sync_out, frame_sync_oe;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, lvl;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] word;  // last result handed over by the core side
  int          n_fail = 0, tests_run = 0, cycles = 0;
  int          per_exp[4] = '{`AOPC_TSCLK0_CYC, `AOPC_TSCLK1_CYC, `AOPC_TSCLK2_CYC, `AOPC_TSCLK3_CYC};
  aopc_output_port i_aopc_output_port (
    .ref_clk, .reset_n, .conv_result, .conv_done, .conv_busy, .byte_order_select,
    .output_code_format, .serial_parallel_select, .data_in, .data_out, .data_oe,
    .serial_clock_in, .serial_clock_out, .serial_clock_oe, .frame_sync_out, .frame_sync_oe,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  aopc_host_model i_aopc_host_model (
    .ref_clk, .data_out, .data_oe, .serial_clock_out, .serial_clock_oe, .data_in,
    .serial_clock_in
  );
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // hang guard: the whole run needs just over a thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  // expected word: code format flips the msb first, then the bytes may swap
  function automatic logic [15:0] fmt(input logic [15:0] r, input logic ocf, input logic bos);
    logic [15:0] w;
    w = r;
    w[15] = ocf ? r[15] : ~r[15];
    return bos ? {w[7:0], w[15:8]} : w;
  endfunction : fmt
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wait_n
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    // a write that never answers is a failure, not a silent stale response
    if (s_axi_bvalid !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED at %0t: write got no response", $time);
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    if (s_axi_rvalid !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED at %0t: read got no data", $time);
    end
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read
  task automatic pulse_done(input logic [15:0] w);
    @(posedge ref_clk);
    word = w;
    conv_result <= w;
    conv_done <= 1'b1;
    @(posedge ref_clk);
    conv_done <= 1'b0;
  endtask : pulse_done
  // config lines are only moved while idle; five cycles cover the pin synchronisers
  task automatic set_cfg(input logic [1:0] dv, input logic ext, input logic fpi,
                         input logic sci, input logic rdc);
    @(posedge ref_clk);
    i_aopc_host_model.cfg <= {rdc, sci, fpi, ext, dv};
    wait_n(5);
  endtask : set_cfg
  task automatic wait_bits();
    int n;
    n = 0;
    while (i_aopc_host_model.nbits < 16 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    // a frame that never completes must not pass on stale captured bits
    if (n >= 2000) begin
      n_fail++;
      $display("CHECK FAILED at %0t: serial frame incomplete", $time);
    end
    wait_n(40);
  endtask : wait_bits
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  initial begin
    wait_n(3);
    reset_n <= 1'b1;
    axi_read(`AOPC_REG_CTRL);
    check(rd, 32'h1, "enable reset value");
    axi_read(8'h0c);
    check(rsp, `AOPC_RESP_SLVERR, "unmapped read");
    axi_write(8'h0c, 32'h0);
    check(rsp, `AOPC_RESP_SLVERR, "unmapped write");
    axi_write(`AOPC_REG_CTRL, 32'h0);
    check(rsp, `AOPC_RESP_OKAY, "write response");
    wait_n(2);
    check(data_oe, 16'h0000, "disabled port");
    axi_write(`AOPC_REG_CTRL, 32'h1);
    wait_n(2);
    check(data_oe, 16'hffff, "parallel enables");
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      output_code_format <= k[0];
      byte_order_select <= k[1];
      wait_n(4);
      pulse_done(16'h8a35);
      wait_n(3);
      check(data_out, fmt(16'h8a35, k[0], k[1]), "parallel word");
      axi_read(`AOPC_REG_RESULT);
      check(rd[15:0], fmt(16'h8a35, k[0], k[1]), "result register");
    end
    $display("test parallel done");
    i_aopc_host_model.ser <= 1'b1;
    serial_parallel_select <= 1'b1;
    output_code_format <= 1'b0;
    byte_order_select <= 1'b1;
    for (int d = 0; d < 4; d++) begin
      set_cfg(d[1:0], 1'b0, d[0], 1'b0, 1'b0);
      check(data_oe, 16'h0100, "serial enables");
      check(serial_clock_oe, 1'b1, "clock driven");
      check(frame_sync_out, d[0], "frame idle");
      i_aopc_host_model.nbits = 0;
      pulse_done(16'h5c3a + d[15:0]);
      wait_bits();
      check(i_aopc_host_model.bits[15:0], fmt(word, 1'b0, 1'b1), "master word");
      check(i_aopc_host_model.per, per_exp[d], "clock period");
      check(frame_sync_out, d[0], "frame end");
    end
    lvl = ~serial_clock_out;
    set_cfg(2'b11, 1'b0, 1'b0, 1'b1, 1'b1);
    check(serial_clock_out, lvl, "inverted idle clock");
    i_aopc_host_model.nbits = 0;
    // a fresh result first, so the streamed word differs from the last frame
    pulse_done(16'h1e69);
    conv_busy <= 1'b1;
    wait_bits();
    conv_busy <= 1'b0;
    check(i_aopc_host_model.bits[15:0], fmt(word, 1'b0, 1'b1), "during convert");
    check(i_aopc_host_model.per, `AOPC_TSCLK0_CYC, "divider ignored");
    $display("test master done");
    output_code_format <= 1'b1;
    byte_order_select <= 1'b0;
    set_cfg(2'b00, 1'b1, 1'b0, 1'b0, 1'b1);
    check(serial_clock_oe, 1'b0, "clock released");
    // serial, external clock, chain level high, idle, sixteen bits last shifted
    axi_read(`AOPC_REG_STATUS);
    check(rd, 32'h0000_1007, "status word");
    pulse_done(16'h3c96);
    wait_n(2);
    i_aopc_host_model.slave_read(17);
    check(i_aopc_host_model.bits[16:1], fmt(16'h3c96, 1'b1, 1'b0), "slave word");
    check(i_aopc_host_model.bits[0], 1'b1, "chained bit");
    $display("test slave done");
    stop_test();
  end
endmodule : aopc_output_port_test
